// >>> hw/srl_master.v
// Notes on behaviour
// RULE1: every frame carries exactly eight data bits.
// RULE2: bits go out and come in most significant first.
// RULE3: clock idles low, data is set up before the rising edge that samples it.
// RULE4: each frame sends one byte and captures one byte at once.
// RULE5: the master makes and drives the bit clock from its own clock.
// RULE6: the bit rate is 1 Mbps, a fixed division of the main clock.
// RULE7: the channel works only while its clock enable input is high; the code tests it only when taking a request, not during a transfer.
// RULE8: a transaction starts the channel, then drives select low.
// RULE9: a write's first byte is a one marker bit and a seven-bit address.
// RULE10: on the first buffer-empty point the second byte is loaded, data for a write.
// RULE11: on the second buffer-empty point the first received byte is dropped.
// RULE12: at transfer end the second byte is kept, select goes high, channel stops; the code keeps that byte in RD_DATA for reads only.
// RULE13: the slave data line is open drain and reads high when not pulled low.
// RULE14: a read's first byte has a zero marker, its second byte is 00, the reply is kept.
// RULE15: select stays high the least deselect width between transactions.
`include "srl_regs.vh"
`default_nettype none
module srl_master
(
    // clock and reset
    input  wire       MCLK,
    input  wire       SYS_RST,
    // control
    input  wire       UNIT_CLK_EN,
    input  wire       REQ,
    input  wire       REQ_WRITE,
    input  wire [6:0] REQ_ADDR,
    input  wire [7:0] REQ_DATA,
    output wire       REQ_READY,
    output reg        DONE,
    output reg  [7:0] RD_DATA,
    output wire       BUSY,
    // serial link
    output wire       SCK,
    output wire       MOSI,
    input  wire       MISO,
    output reg        CS_N
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_SEL   = 3'h1;
    localparam [2:0] S_FRM1  = 3'h2;
    localparam [2:0] S_FRM2  = 3'h3;
    localparam [2:0] S_END   = 3'h4;
    localparam [2:0] S_GAP   = 3'h5;
    // deselect width in clocks, cut to the width of its down counter
    localparam integer GAP_CYC = `SRL_DESELECT_CYC;
    localparam [4:0]   GAP     = GAP_CYC[4:0];

    reg [2:0] state;
    reg [7:0] second;
    reg       is_write;
    reg       start;
    reg [7:0] tx;
    reg [4:0] gap;
    reg       m1;
    reg       m2;
    reg       m3;
    reg       miso_s;
    wire      sh_busy;
    wire      sh_done;
    wire [7:0] sh_rx;

    // ----------------------------------------
    // data input synchroniser, change accepted when stages two and three agree
    // ----------------------------------------
    // the line idles high through its pull-up, so every stage resets to one
    // only the second stage reads the first, so a late settle never leaks through
    always @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            m1 <= 1'b1;
            m2 <= 1'b1;
            m3 <= 1'b1;
            miso_s <= 1'b1; // RULE13
        end
        else
        begin
            m1 <= MISO;
            m2 <= m1;
            m3 <= m2;
            if (m2 == m3)
                miso_s <= m3;
        end
    end

    // ready only while idle with the unit clock on; busy spans the gap too
    assign REQ_READY = (state == S_IDLE) && UNIT_CLK_EN; // RULE7
    assign BUSY = (state != S_IDLE);

    // ----------------------------------------
    // byte builders and counter test
    // ----------------------------------------
    // command byte: direction marker above the seven address bits
    function [7:0] first_byte;
        input       wr;
        input [6:0] addr;
        begin
            first_byte = {(wr ? `SRL_RW_WRITE : `SRL_RW_READ), addr}; // RULE9
        end
    endfunction

    // second byte: write data, or the dummy byte for a read
    function [7:0] second_byte;
        input       wr;
        input [7:0] data;
        begin
            second_byte = wr ? data : `SRL_DUMMY_BYTE; // RULE14
        end
    endfunction

    // deselect counter has run out
    function gap_over;
        input [4:0] g;
        begin
            gap_over = (g <= 5'h01);
        end
    endfunction

    // ----------------------------------------
    // shifter
    // ----------------------------------------
    // the shifter sees only the settled data line; its few cycles of lag
    // are small against a half bit of sixty-two clocks
    srl_shift u_shift
    (
        .clk     (MCLK),
        .rst     (SYS_RST),
        .start   (start),
        .tx_byte (tx),
        .busy    (sh_busy),
        .done    (sh_done),
        .rx_byte (sh_rx),
        .sck     (SCK),
        .mosi    (MOSI),
        .miso    (miso_s)
    );

    // ----------------------------------------
    // transaction sequencer
    // ----------------------------------------
    always @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state <= S_IDLE;
            CS_N <= 1'b1;
            DONE <= 1'b0;
            RD_DATA <= 8'h00;
            second <= 8'h00;
            is_write <= 1'b0;
            start <= 1'b0;
            tx <= 8'h00;
            gap <= 5'h00;
        end
        else
        begin
            DONE <= 1'b0;
            start <= 1'b0;
            case (state)
                // wait for an enabled request and latch both bytes at once
                S_IDLE:
                begin
                    if (REQ && UNIT_CLK_EN) // RULE7
                    begin
                        is_write <= REQ_WRITE;
                        tx <= first_byte(REQ_WRITE, REQ_ADDR); // RULE9
                        second <= second_byte(REQ_WRITE, REQ_DATA); // RULE14
                        state <= S_SEL;
                    end
                end
                // select low and first frame launched on the same edge
                S_SEL:
                begin
                    CS_N <= 1'b0; // RULE8
                    start <= 1'b1;
                    state <= S_FRM1;
                end
                // first frame over: load the second byte, the first reply is never kept
                S_FRM1:
                begin
                    if (sh_done) // RULE10
                    begin
                        tx <= second;
                        start <= 1'b1;
                        state <= S_FRM2; // RULE11
                    end
                end
                // second frame over: keep the reply of a read only
                S_FRM2:
                begin
                    if (sh_done && !start)
                    begin
                        if (!is_write)
                            RD_DATA <= sh_rx; // RULE14
                        state <= S_END;
                    end
                end
                // release select and pulse done together
                S_END:
                begin
                    CS_N <= 1'b1; // RULE12
                    DONE <= 1'b1;
                    gap <= GAP;
                    state <= S_GAP;
                end
                // hold select high for the deselect width before going idle
                S_GAP:
                begin
                    if (gap_over(gap)) // RULE15
                        state <= S_IDLE;
                    else
                        gap <= gap - 5'h01;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> hw/srl_regs.vh
`ifndef SRL_REGS_VH
`define SRL_REGS_VH
// frame format
`define SRL_FRAME_BITS      4'h8
`define SRL_BIT_CNT_W       4
// write/read marker in the first byte
`define SRL_RW_WRITE        1'b1
`define SRL_RW_READ         1'b0
`define SRL_DUMMY_BYTE      8'h00
// bit clock: operating clock divided by 2*SRL_HALF_BIT_CYC; SRL_DIV_FIELD is unused
`define SRL_DIV_FIELD       7'h0f
`define SRL_RATE_BPS        1000000
`define SRL_MCLK_HZ         125000000
`define SRL_HALF_BIT_CYC    (`SRL_MCLK_HZ / (2 * `SRL_RATE_BPS))
// least slave deselect width
`define SRL_DESELECT_NS     100
`define SRL_MCLK_NS         8
`define SRL_DESELECT_CYC    ((`SRL_DESELECT_NS + `SRL_MCLK_NS - 1) / `SRL_MCLK_NS)
`endif

// >>> hw/srl_shift.v
`include "srl_regs.vh"
`default_nettype none
// ----------------------------------------
// one eight-bit full-duplex frame
// ----------------------------------------
module srl_shift
(
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // frame control
    input  wire       start,
    input  wire [7:0] tx_byte,
    output reg        busy,
    output reg        done,
    output reg  [7:0] rx_byte,
    // serial lines
    output reg        sck,
    output reg        mosi,
    input  wire       miso
);
    localparam integer HALF_CYC = `SRL_HALF_BIT_CYC;
    localparam [6:0]   HALF     = HALF_CYC[6:0];
    reg [6:0] div;
    reg [3:0] cnt;
    reg [7:0] sh;

    // clock idles low, data set up before first rising edge, sampled on rise
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            rx_byte <= 8'h00;
            sck <= 1'b0;
            mosi <= 1'b0;
            div <= 7'h00;
            cnt <= 4'h0;
            sh <= 8'h00;
        end
        else
        begin
            done <= 1'b0;
            if (!busy)
            begin
                if (start)
                begin
                    busy <= 1'b1;
                    sh <= tx_byte;
                    mosi <= tx_byte[7]; // RULE2
                    div <= 7'h00;
                    cnt <= 4'h0;
                end
            end
            else if (div == HALF - 7'h01) // RULE6
            begin
                div <= 7'h00;
                sck <= ~sck; // RULE5
                if (!sck)
                    sh <= {sh[6:0], miso}; // RULE4
                else
                begin
                    cnt <= cnt + 4'h1;
                    if (cnt == `SRL_FRAME_BITS - 4'h1) // RULE1
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        rx_byte <= sh;
                    end
                    else
                        mosi <= sh[7]; // RULE3
                end
            end
            else
                div <= div + 7'h01;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/srl_slave_model.sv
`default_nettype none
// ----------------------------------------
// register slave at the far end of the link
// ----------------------------------------
module srl_slave_model
(
    // serial link
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       cs_n,
    output wire logic       miso,
    // last byte pair seen
    output var  logic [7:0] last_cmd,
    output var  logic [7:0] last_b2
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:127];
    logic [7:0] sr;
    logic [7:0] out_sr;
    logic [4:0] cnt;
    // capture on the rising clock, first byte command, second byte data
    always @(posedge sck or posedge cs_n)
        if (cs_n)
            cnt <= 5'h00;
        else
        begin
            sr <= {sr[6:0], mosi};
            cnt <= cnt + 5'h01;
            if (cnt == 5'h07)
                last_cmd <= {sr[6:0], mosi};
            if (cnt == 5'h0f)
                last_b2 <= {sr[6:0], mosi};
            if (cnt == 5'h0f && last_cmd[7])
                mem[last_cmd[6:0]] <= {sr[6:0], mosi};
        end
    // launch on the falling clock, reply loaded after the command byte
    always @(negedge sck or posedge cs_n)
        if (cs_n)
            out_sr <= 8'hff;
        else if (cnt == 5'h08)
            out_sr <= last_cmd[7] ? 8'hff : mem[last_cmd[6:0]];
        else
            out_sr <= {out_sr[6:0], 1'b1};
    // open drain with pull-up: high unless pulled low
    assign miso = cs_n | out_sr[7];
endmodule
`default_nettype wire

// >>> testbench/srl_master_checker.sv
`default_nettype none
module srl_master_checker
(
    // clock, reset and control
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic UNIT_CLK_EN,
    input wire logic REQ,
    input wire logic REQ_READY,
    input wire logic DONE,
    input wire logic BUSY,
    // serial link
    input wire logic SCK,
    input wire logic MOSI,
    input wire logic CS_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] hcnt;
    logic [4:0] rcnt;
    logic       sck_q;
    // half-bit timer and count of clock rises within one select
    always_ff @(posedge MCLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            hcnt <= 7'h00;
            rcnt <= 5'h00;
            sck_q <= 1'b0;
        end
        else
        begin
            sck_q <= SCK;
            hcnt <= (SCK != sck_q) ? 7'h00 : hcnt + 7'h01;
            rcnt <= CS_N ? 5'h00 : rcnt + {4'h0, SCK & ~sck_q};
        end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    property p_idle; CS_N |-> !SCK; endproperty
    a_idle: assert property (p_idle) else $error("clock not idle low");
    property p_start; REQ && REQ_READY |-> ##[1:2] !CS_N; endproperty
    a_start: assert property (p_start) else $error("select late");
    property p_ready; !UNIT_CLK_EN && !BUSY |=> !BUSY && CS_N; endproperty
    a_ready: assert property (p_ready) else $error("request taken while unit off");
    property p_half; $fell(SCK) |-> hcnt == 7'h3d; endproperty
    a_half: assert property (p_half) else $error("half bit wrong");
    property p_bits; $rose(CS_N) |-> rcnt == 5'h10; endproperty
    a_bits: assert property (p_bits) else $error("bit count wrong");
    property p_done; DONE |-> CS_N ##1 !DONE; endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
    property p_gap; $rose(CS_N) |-> CS_N[*7] ##1 CS_N[*6]; endproperty
    a_gap: assert property (p_gap) else $error("deselect too short");
    property p_hold; SCK |=> !SCK || $stable(MOSI); endproperty
    a_hold: assert property (p_hold) else $error("data moved while clock high");
endmodule
bind srl_master srl_master_checker chk_inst (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .UNIT_CLK_EN(UNIT_CLK_EN), .REQ(REQ), .REQ_READY(REQ_READY), .DONE(DONE),
    .BUSY(BUSY), .SCK(SCK), .MOSI(MOSI), .CS_N(CS_N));
`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       clk_en = 1'b0;
    logic       req = 1'b0;
    logic       req_write = 1'b0;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_data = 8'h00;
    wire  logic req_ready, done, busy, sck, mosi, miso, cs_n;
    wire  logic [7:0] rd_data, last_cmd, last_b2;
    logic [6:0] addr_t [3] = '{7'h00, 7'h7f, 7'h0b};
    logic [7:0] data_t [3] = '{8'h1e, 8'hc4, 8'h01};
    int         err_total = 0;
    int         comparisons = 0;
    srl_master srl_master_inst (.MCLK(mclk), .SYS_RST(sys_rst), .UNIT_CLK_EN(clk_en),
        .REQ(req), .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_DATA(req_data),
        .REQ_READY(req_ready), .DONE(done), .RD_DATA(rd_data), .BUSY(busy), .SCK(sck),
        .MOSI(mosi), .MISO(miso), .CS_N(cs_n));
    srl_slave_model srl_slave_model_inst (.sck(sck), .mosi(mosi), .cs_n(cs_n), .miso(miso),
        .last_cmd(last_cmd), .last_b2(last_b2));
    // compare one byte, flags zero-extended
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one transaction: wait ready, hold request one edge, wait done
    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge mclk);
        while (req_ready !== 1'b1 && n++ < 100) @(negedge mclk);
        chk("req_ready", 8'h01, {7'h00, req_ready});
        @(posedge mclk);
        req <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_data <= d;
        @(posedge mclk);
        req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n++ < 4000) @(negedge mclk);
        chk("done", 8'h01, {7'h00, done});
    endtask
    // clock and watchdog
    initial forever #4 mclk = ~mclk;
    initial
    begin
        #400000;
        err_total++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        req <= 1'b1;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        chk("cs_n", 8'h01, {7'h00, cs_n});
        chk("busy", 8'h00, {7'h00, busy});
        @(posedge mclk);
        req <= 1'b0;
        clk_en <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, addr_t[i], data_t[i]);
            chk("cmd", {1'b1, addr_t[i]}, last_cmd);
            chk("byte2", data_t[i], last_b2);
        end
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b0, addr_t[i], 8'h5a);
            chk("cmd", {1'b0, addr_t[i]}, last_cmd);
            chk("byte2", 8'h00, last_b2);
            chk("rd_data", data_t[i], rd_data);
        end
        xfer(1'b1, 7'h0b, 8'h0f);
        chk("rd_data", data_t[2], rd_data);
        give_verdict();
    end
endmodule
`default_nettype wire
